// ==== hw/fsc_pkg.sv ====
/*
  Shared constants and types for the flow signal conditioning block:
  register offsets, field positions, reset values, timing and bus structs.
  Assumes a 40 MHz system clock and an AXI4-Lite master on the same clock.
*/
`default_nettype none
package fsc_pkg;
  // timing, each figure in its own unit and then in clock cycles
  localparam int CLK_HZ = 40_000_000;
  localparam int VIEW_S = 7;
  localparam int ERRSHOW_S = 2;
  localparam int SAMPLE_HZ = 1000;
  localparam int VIEW_CYC = VIEW_S * CLK_HZ;
  localparam int ERRSHOW_CYC = ERRSHOW_S * CLK_HZ;
  localparam int SAMPLE_CYC = CLK_HZ / SAMPLE_HZ;

  // arithmetic formats
  localparam int FRAC = 8;
  localparam int KF_FRAC = 14;
  localparam logic [15:0] KF_ONE = 16'h4000;
  localparam logic [6:0] PCT_FULL = 7'h64;
  localparam logic [15:0] ACCESS_CODE = 16'h2207;

  // register byte addresses
  localparam logic [31:0] A_CTRL = 32'h00;
  localparam logic [31:0] A_CMD = 32'h04;
  localparam logic [31:0] A_CODE = 32'h08;
  localparam logic [31:0] A_CUT = 32'h0C;
  localparam logic [31:0] A_KFAC = 32'h10;
  localparam logic [31:0] A_FILT = 32'h14;
  localparam logic [31:0] A_FDLY = 32'h18;
  localparam logic [31:0] A_FSCALE = 32'h1C;
  localparam logic [31:0] A_STATUS = 32'h20;
  localparam logic [31:0] A_FLOW = 32'h24;
  localparam logic [31:0] A_DISP = 32'h28;
  localparam logic [31:0] A_TOTAL = 32'h2C;
  localparam logic [31:0] A_BATCH = 32'h30;
  localparam logic [31:0] A_DENS = 32'h34;

  // field positions
  localparam int CTRL_ALT = 0;
  localparam int CTRL_REV = 1;
  localparam int CTRL_BKEY = 2;
  localparam int CTRL_MASS = 3;
  localparam int CTRL_PC = 4;
  localparam int CTRL_UN = 8;
  localparam int CMD_CLRTOT = 0;
  localparam int CMD_SAVE = 1;
  localparam int CMD_RECALL = 2;
  localparam int CMD_CONFIRM = 3;
  localparam int CMD_DECLINE = 4;
  localparam int CUT_LF = 0;
  localparam int CUT_STEP = 8;
  localparam int CUT_DENS = 16;
  localparam int FILT_FS = 0;
  localparam int FILT_DS = 4;
  localparam int FDLY_ON = 0;
  localparam int FDLY_OFF = 16;
  localparam int ST_OPEN = 0;
  localparam int ST_ERR = 1;
  localparam int ST_VIEW = 2;
  localparam int ST_FAULT = 3;
  localparam int ST_PEND = 4;
  localparam int ST_CUT = 5;
  localparam int K_DISP = 0;
  localparam int K_BATCH = 1;
  localparam int K_ERR = 2;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [2:0] {
    ACC_LOCKED = 3'h1,
    ACC_OPEN = 3'h2,
    ACC_ERR = 3'h4
  } fsc_acc_t;

  typedef struct packed {
    logic alt;
    logic rev;
    logic bkey;
    logic mass;
    logic [1:0] pcomp;
    logic [3:0] units;
    logic [6:0] cut_pct;
    logic [6:0] step_pct;
    logic [15:0] dcut;
    logic [15:0] kfac;
    logic [3:0] fshift;
    logic [3:0] dshift;
    logic [15:0] on_dly;
    logic [15:0] off_dly;
    logic [15:0] fscale;
  } fsc_cfg_t;

  localparam fsc_cfg_t CFG_RST = '{alt: 1'h0, rev: 1'h0, bkey: 1'h0,
    mass: 1'h1, pcomp: 2'h0, units: 4'h0, cut_pct: 7'h00,
    step_pct: 7'h63, dcut: 16'h0000, kfac: KF_ONE, fshift: 4'h4,
    dshift: 4'h4, on_dly: 16'h0000, off_dly: 16'h0000,
    fscale: 16'h7FFF};

  typedef struct packed {
    logic [31:0] awaddr;
    logic awvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic wvalid;
    logic bready;
    logic [31:0] araddr;
    logic arvalid;
    logic rready;
  } fsc_axil_req_t;

  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } fsc_axil_rsp_t;

  typedef struct packed {
    fsc_cfg_t cfg;
    fsc_cfg_t bk;
    logic mode_pend;
    logic pend_mass;
    fsc_acc_t acc;
    logic [31:0] err_cnt;
    logic [2:0] sy1;
    logic [2:0] sy2;
    logic [2:0] prv;
    logic [31:0] tick_cnt;
    logic [31:0] view_cnt;
    logic view;
    logic signed [31:0] filt;
    logic signed [31:0] flow;
    logic signed [31:0] disp;
    logic signed [31:0] total;
    logic signed [31:0] batch;
    logic [15:0] dens;
    logic cut;
    logic fault;
    logic [15:0] f_cnt;
    logic aw_got;
    logic [31:0] aw_addr;
    logic w_got;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    fsc_axil_rsp_t rsp;
  } fsc_state_t;
endpackage
`default_nettype wire

// ==== hw/fsc_top.sv ====
/*
  Flow signal conditioning: first-order flow filter with step bypass,
  low-flow and low-density suppression, direction and scale factor,
  totals, display view control, access code, fault delays, AXI4-Lite.
  Assumes flow and density samples come from logic on clk_in; keys and
  the fault condition are asynchronous pins.
*/
`timescale 1ns/1ps
`default_nettype none
module fsc_top #(
  parameter int P_SAMPLE_CYC = fsc_pkg::SAMPLE_CYC,
  parameter int P_VIEW_CYC = fsc_pkg::VIEW_CYC,
  parameter int P_ERR_CYC = fsc_pkg::ERRSHOW_CYC
) (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire fsc_pkg::fsc_axil_req_t axi_in,
  output var fsc_pkg::fsc_axil_rsp_t axi_out,
  input wire logic signed [15:0] flow_in,
  input wire logic [15:0] dens_in,
  input wire logic disp_key_in,
  input wire logic batch_key_in,
  input wire logic fault_cond_in,
  output var logic view_out,
  output var logic fault_lamp_out,
  output var logic fault_ctrl_out,
  output var logic signed [31:0] flow_out,
  output var logic signed [31:0] disp_out,
  output var logic signed [31:0] total_out,
  output var logic signed [31:0] batch_out,
  output var logic [15:0] dens_out,
  output var logic [1:0] pcomp_out
);
  import fsc_pkg::*;

  fsc_state_t s;
  fsc_state_t n;

  logic tick;
  logic [2:0] kedge;
  logic signed [31:0] x_fx;
  logic signed [31:0] diff;
  logic [31:0] dabs;
  logic step_hit;
  logic signed [31:0] filt_nx;
  logic [31:0] fabs;
  logic cut_now;
  logic signed [31:0] fint;
  logic signed [31:0] fdir;
  logic signed [63:0] kprod;
  logic signed [31:0] flow_nx;
  logic signed [31:0] ddiff;
  logic [32:0] wr_old;
  logic [32:0] rd_val;
  logic [31:0] wmask;
  logic [31:0] wm;
  logic [15:0] dly;

  // register read decode, returns {mapped, data}
  function automatic logic [32:0] rd_reg(input logic [31:0] a,
                                         input fsc_state_t st);
    logic [31:0] r;
    logic ok;
    r = '0;
    ok = 1'b1;
    if (a == A_CTRL) begin
      r[CTRL_ALT] = st.cfg.alt;
      r[CTRL_REV] = st.cfg.rev;
      r[CTRL_BKEY] = st.cfg.bkey;
      r[CTRL_MASS] = st.cfg.mass;
      r[CTRL_PC +: 2] = st.cfg.pcomp;
      r[CTRL_UN +: 4] = st.cfg.units;
    end else if (a == A_CMD || a == A_CODE) begin
      r = '0; // write-only
    end else if (a == A_CUT) begin
      r[CUT_LF +: 7] = st.cfg.cut_pct;
      r[CUT_STEP +: 7] = st.cfg.step_pct;
      r[CUT_DENS +: 16] = st.cfg.dcut;
    end else if (a == A_KFAC) begin
      r = 32'(st.cfg.kfac);
    end else if (a == A_FILT) begin
      r[FILT_FS +: 4] = st.cfg.fshift;
      r[FILT_DS +: 4] = st.cfg.dshift;
    end else if (a == A_FDLY) begin
      r[FDLY_ON +: 16] = st.cfg.on_dly;
      r[FDLY_OFF +: 16] = st.cfg.off_dly;
    end else if (a == A_FSCALE) begin
      r = 32'(st.cfg.fscale);
    end else if (a == A_STATUS) begin
      r[ST_OPEN] = (st.acc == ACC_OPEN);
      r[ST_ERR] = (st.acc == ACC_ERR);
      r[ST_VIEW] = st.view;
      r[ST_FAULT] = st.fault;
      r[ST_PEND] = st.mode_pend;
      r[ST_CUT] = st.cut;
    end else if (a == A_FLOW) begin
      r = st.flow;
    end else if (a == A_DISP) begin
      r = st.disp;
    end else if (a == A_TOTAL) begin
      r = st.total;
    end else if (a == A_BATCH) begin
      r = st.batch;
    end else if (a == A_DENS) begin
      r = 32'(st.dens);
    end else begin
      ok = 1'b0;
    end
    return {ok, r};
  endfunction

  // sample strobe and key edges from the synchronised pins
  assign tick = (s.tick_cnt == 32'(P_SAMPLE_CYC - 1));
  assign kedge = s.sy2 & ~s.prv;

  // flow filter datapath, fixed point with FRAC fraction bits
  assign x_fx = 32'(flow_in) <<< FRAC;
  assign diff = x_fx - s.filt;
  assign dabs = diff[31] ? 32'(-diff) : 32'(diff);
  assign step_hit = (48'(dabs) * 48'(PCT_FULL)) >
    ((48'(s.cfg.step_pct) * 48'(s.cfg.fscale)) << FRAC);
  assign filt_nx = step_hit ? x_fx :
    s.filt + (diff >>> s.cfg.fshift);
  assign fabs = filt_nx[31] ? 32'(-filt_nx) : 32'(filt_nx);

  // suppression: low flow in percent of full scale, low density
  assign cut_now = ((48'(fabs) * 48'(PCT_FULL)) <
    ((48'(s.cfg.cut_pct) * 48'(s.cfg.fscale)) << FRAC))
    || (dens_in < s.cfg.dcut);

  // direction and scale factor
  assign fint = filt_nx >>> FRAC;
  assign fdir = s.cfg.rev ? -fint : fint;
  assign kprod = 64'(fdir) * signed'(64'(s.cfg.kfac));
  assign flow_nx = cut_now ? 32'sh0 : 32'(kprod >>> KF_FRAC);
  assign ddiff = flow_nx - s.disp;

  // write data merged under byte strobes with the present value
  assign wr_old = rd_reg(s.aw_addr, s);
  assign wmask = {{8{s.w_strb[3]}}, {8{s.w_strb[2]}},
                  {8{s.w_strb[1]}}, {8{s.w_strb[0]}}};
  assign wm = (wr_old[31:0] & ~wmask) | (s.w_data & wmask);
  assign rd_val = rd_reg(axi_in.araddr, s);
  assign dly = s.fault ? s.cfg.off_dly : s.cfg.on_dly;

  // next-state logic for the whole block
  always_comb begin
    n = s;
    n.sy1 = {fault_cond_in, batch_key_in, disp_key_in};
    n.sy2 = s.sy1;
    n.prv = s.sy2;
    n.tick_cnt = tick ? '0 : s.tick_cnt + 32'h1;

    // view selection
    if (s.cfg.alt) begin
      if (s.view_cnt == 32'(P_VIEW_CYC - 1)) begin
        n.view_cnt = '0;
        n.view = ~s.view;
      end else begin
        n.view_cnt = s.view_cnt + 32'h1;
      end
    end else begin
      n.view_cnt = '0;
      if (kedge[K_DISP]) begin
        n.view = ~s.view;
      end
    end

    // access error display timer
    case (s.acc)
      ACC_ERR: begin
        if (s.err_cnt == 32'(P_ERR_CYC - 1)) begin
          n.acc = ACC_LOCKED;
          n.err_cnt = '0;
        end else begin
          n.err_cnt = s.err_cnt + 32'h1;
        end
      end
      ACC_OPEN: n.err_cnt = '0;
      ACC_LOCKED: n.err_cnt = '0;
      default: n.acc = ACC_LOCKED;
    endcase

    // per-sample processing
    if (tick) begin
      n.filt = filt_nx;
      n.cut = cut_now;
      n.flow = flow_nx;
      n.disp = s.disp + (ddiff >>> s.cfg.dshift);
      n.dens = dens_in;
      n.total = s.total + flow_nx;
      n.batch = s.batch + flow_nx;
    end

    // fault on and off delays counted in samples
    if (s.sy2[K_ERR] == s.fault) begin
      n.f_cnt = '0;
    end else if (s.f_cnt >= dly) begin
      n.fault = s.sy2[K_ERR];
      n.f_cnt = '0;
    end else if (tick) begin
      n.f_cnt = s.f_cnt + 16'h1;
    end

    // reset key clears batch when enabled
    if (kedge[K_BATCH] && s.cfg.bkey) begin
      n.batch = '0;
    end

    // write address and data channels, taken in either order
    if (axi_in.awvalid && s.rsp.awready) begin
      n.aw_got = 1'b1;
      n.aw_addr = axi_in.awaddr;
    end
    if (axi_in.wvalid && s.rsp.wready) begin
      n.w_got = 1'b1;
      n.w_data = axi_in.wdata;
      n.w_strb = axi_in.wstrb;
    end
    if (s.rsp.bvalid && axi_in.bready) begin
      n.rsp.bvalid = 1'b0;
    end

    // register write once both halves are held
    if (s.aw_got && s.w_got && !s.rsp.bvalid) begin
      n.aw_got = 1'b0;
      n.w_got = 1'b0;
      n.rsp.bvalid = 1'b1;
      n.rsp.bresp = RESP_OKAY;
      if (!wr_old[32] || s.aw_addr >= A_STATUS) begin
        n.rsp.bresp = RESP_SLVERR;
      end else if (s.aw_addr == A_CODE) begin
        if (s.acc != ACC_ERR) begin
          n.acc = (wm[15:0] == ACCESS_CODE) ? ACC_OPEN : ACC_ERR;
        end
      end else if (s.acc == ACC_OPEN) begin
        if (s.aw_addr == A_CTRL) begin
          n.cfg.alt = wm[CTRL_ALT];
          n.cfg.rev = wm[CTRL_REV];
          n.cfg.bkey = wm[CTRL_BKEY];
          n.cfg.pcomp = wm[CTRL_PC +: 2];
          n.cfg.units = wm[CTRL_UN +: 4];
          if (wm[CTRL_MASS] != s.cfg.mass) begin
            n.mode_pend = 1'b1;
            n.pend_mass = wm[CTRL_MASS];
          end
        end else if (s.aw_addr == A_CMD) begin
          if (wm[CMD_CLRTOT]) begin
            n.total = '0;
          end
          if (wm[CMD_SAVE]) begin
            n.bk = s.cfg;
          end
          if (wm[CMD_RECALL]) begin
            n.cfg = s.bk;
          end
          if (wm[CMD_CONFIRM] && s.mode_pend) begin
            n.cfg.mass = s.pend_mass;
            n.cfg.units = CFG_RST.units;
            n.total = '0;
            n.mode_pend = 1'b0;
          end else if (wm[CMD_DECLINE]) begin
            n.mode_pend = 1'b0;
          end
        end else if (s.aw_addr == A_CUT) begin
          n.cfg.cut_pct = wm[CUT_LF +: 7];
          n.cfg.step_pct = wm[CUT_STEP +: 7];
          n.cfg.dcut = wm[CUT_DENS +: 16];
        end else if (s.aw_addr == A_KFAC) begin
          n.cfg.kfac = wm[15:0];
        end else if (s.aw_addr == A_FILT) begin
          n.cfg.fshift = wm[FILT_FS +: 4];
          n.cfg.dshift = wm[FILT_DS +: 4];
        end else if (s.aw_addr == A_FDLY) begin
          n.cfg.on_dly = wm[FDLY_ON +: 16];
          n.cfg.off_dly = wm[FDLY_OFF +: 16];
        end else begin
          n.cfg.fscale = wm[15:0];
        end
      end
    end
    n.rsp.awready = !n.aw_got;
    n.rsp.wready = !n.w_got;

    // read channel, one read under way at a time
    if (axi_in.arvalid && s.rsp.arready) begin
      n.rsp.arready = 1'b0;
      n.rsp.rvalid = 1'b1;
      n.rsp.rdata = rd_val[31:0];
      n.rsp.rresp = rd_val[32] ? RESP_OKAY : RESP_SLVERR;
    end else if (s.rsp.rvalid && axi_in.rready) begin
      n.rsp.rvalid = 1'b0;
      n.rsp.arready = 1'b1;
    end
  end

  // state register with synchronous reset to constants
  always_ff @(posedge clk_in) begin
    if (srst_in) begin
      s <= '0;
      s.cfg <= CFG_RST;
      s.bk <= CFG_RST;
      s.acc <= ACC_LOCKED;
      s.rsp.awready <= 1'b1;
      s.rsp.wready <= 1'b1;
      s.rsp.arready <= 1'b1;
    end else begin
      s <= n;
    end
  end

  // outputs straight from the state register
  assign axi_out = s.rsp;
  assign view_out = s.view;
  assign fault_lamp_out = s.fault;
  assign fault_ctrl_out = s.fault;
  assign flow_out = s.flow;
  assign disp_out = s.disp;
  assign total_out = s.total;
  assign batch_out = s.batch;
  assign dens_out = s.dens;
  assign pcomp_out = s.cfg.pcomp;
endmodule
`default_nettype wire

// ==== testbench/fsc_assertions.sv ====
/*
  Port checker for fsc_top: bus handshakes, fault outputs, density path.
  Assumes one clock domain and the synchronous reset of fsc_top.
*/
`timescale 1ns/1ps
`default_nettype none
module fsc_checker (
  input wire logic clk_in,
  input wire logic srst_in,
  input wire fsc_pkg::fsc_axil_req_t axi_in,
  input wire fsc_pkg::fsc_axil_rsp_t axi_out,
  input wire logic [15:0] dens_in,
  input wire logic fault_lamp_out,
  input wire logic fault_ctrl_out,
  input wire logic [15:0] dens_out
);
  import fsc_pkg::*;
  default clocking @(posedge clk_in); endclocking
  default disable iff (srst_in);
  // lamp and control output show one delayed fault
  chk_fault_pair: assert property (fault_lamp_out == fault_ctrl_out)
    else $error("fault lamp and control output differ");
  // density reaches the output untouched by any cutoff
  chk_dens_pass: assert property ($changed(dens_out) |->
    dens_out == $past(dens_in)) else $error("density output altered");
  // responses stand until taken
  chk_b_hold: assert property (axi_out.bvalid && !axi_in.bready |=>
    axi_out.bvalid && $stable(axi_out.bresp)) else $error("b dropped");
  chk_r_hold: assert property (axi_out.rvalid && !axi_in.rready |=>
    axi_out.rvalid && $stable(axi_out.rdata)) else $error("r dropped");
  // read answers one cycle after the address is taken
  chk_rd_lat: assert property (axi_in.arvalid && axi_out.arready |=>
    axi_out.rvalid && !axi_out.arready) else $error("read late");
  chk_rd_err: assert property (axi_in.arvalid && axi_out.arready &&
    axi_in.araddr > A_DENS |=> axi_out.rresp == RESP_SLVERR &&
    axi_out.rdata == 32'h0) else $error("unmapped read accepted");
  chk_aw_block: assert property (axi_in.awvalid && axi_out.awready |=>
    !axi_out.awready) else $error("second address taken");
  // write answer two edges after address and data arrive together
  chk_wr_err: assert property (axi_in.awvalid && axi_out.awready &&
    axi_in.wvalid && axi_out.wready && !axi_out.bvalid &&
    axi_in.awaddr >= A_STATUS |-> ##2 axi_out.bvalid &&
    axi_out.bresp == RESP_SLVERR) else $error("bad write accepted");
  chk_wr_ok: assert property (axi_in.awvalid && axi_out.awready &&
    axi_in.wvalid && axi_out.wready && !axi_out.bvalid &&
    axi_in.awaddr < A_STATUS |-> ##2 axi_out.bvalid &&
    axi_out.bresp == RESP_OKAY) else $error("write answer wrong");
endmodule
bind fsc_top fsc_checker u_chk (.clk_in(clk_in), .srst_in(srst_in),
  .axi_in(axi_in), .axi_out(axi_out), .dens_in(dens_in),
  .fault_lamp_out(fault_lamp_out), .fault_ctrl_out(fault_ctrl_out),
  .dens_out(dens_out));
`default_nettype wire

// ==== testbench/fsc_partner.sv ====
/*
  Sensor front end and operator keypad model for fsc_top.
  Assumes callers run its tasks from the bench on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module fsc_partner (
  input wire logic clk_in,
  output var logic signed [15:0] flow_out,
  output var logic [15:0] dens_out,
  output var logic disp_key_out,
  output var logic batch_key_out,
  output var logic fault_cond_out
);
  // idle front end and released keys
  initial begin
    flow_out = 16'h0;
    dens_out = 16'h0;
    disp_key_out = 1'b0;
    batch_key_out = 1'b0;
    fault_cond_out = 1'b0;
  end
  // new measurement pair, held until the next one
  task automatic set_meas(input logic signed [15:0] f,
    input logic [15:0] d);
    @(posedge clk_in);
    flow_out <= f;
    dens_out <= d;
  endtask
  // key held longer than the pin synchroniser needs
  task automatic press(input logic b);
    @(posedge clk_in);
    if (b) batch_key_out <= 1'b1;
    else disp_key_out <= 1'b1;
    repeat (6) @(posedge clk_in);
    batch_key_out <= 1'b0;
    disp_key_out <= 1'b0;
  endtask
  task automatic set_fault(input logic v);
    @(posedge clk_in);
    fault_cond_out <= v;
  endtask
endmodule
`default_nettype wire

// ==== testbench/flow_signal_conditioning_tb.sv ====
/*
  Self-checking bench for fsc_top with short sample, view, error counts.
  Assumes fsc_partner and the bound checker are compiled before it.
*/
`timescale 1ns/1ps
`default_nettype none
module flow_signal_conditioning_tb;
  import fsc_pkg::*;
  typedef struct {
    logic [31:0] ctrl, cut, kfac;
    logic signed [15:0] f;
    logic [15:0] d;
    logic signed [31:0] q;
  } fsc_row_t;
  logic clk_in = 1'b0;
  logic srst_in = 1'b1;
  fsc_axil_req_t axi = '0;
  fsc_axil_rsp_t rsp;
  logic signed [15:0] fl;
  logic [15:0] dn, dens_o;
  logic kd, kb, fc, view, lamp, fctl, v1;
  logic signed [31:0] flow_o, tot, bat, disp_o;
  logic [3:0] ws = 4'hF;
  logic [1:0] pc, rd_r;
  logic [31:0] rd_d, tv, bv;
  int fail_count = 0;
  int cmp_count = 0;
  int n, c;
  logic [31:0] ra [8] = '{A_CTRL, A_CUT, A_KFAC, A_FILT, A_FDLY, A_FSCALE,
    A_STATUS, 32'h38};
  logic [31:0] rv [8] = '{32'h8, 32'h6300, 32'h4000, 32'h44, 32'h0,
    32'h7FFF, 32'h0, 32'h0};
  // step threshold kept at 99 percent in every row
  fsc_row_t rows [6] = '{
    '{32'h8, 32'h6300, 32'h4000, 16'sh1000, 16'h100, 32'sh1000},
    '{32'hA, 32'h6300, 32'h4000, 16'sh1000, 16'h100, -32'sh1000},
    '{32'h8, 32'h6300, 32'h2000, 16'sh1000, 16'h100, 32'sh800},
    '{32'h8, 32'h6300, 32'h4000, -16'sh1000, 16'h100, -32'sh1000},
    '{32'h8, 32'h2006300, 32'h4000, 16'sh1000, 16'h100, 32'sh0},
    '{32'h8, 32'h6364, 32'h4000, 16'sh10, 16'h100, 32'sh0}};

  always #12.5 clk_in = ~clk_in;

  fsc_partner fe (.clk_in(clk_in), .flow_out(fl), .dens_out(dn),
    .disp_key_out(kd), .batch_key_out(kb), .fault_cond_out(fc));
  fsc_top #(.P_SAMPLE_CYC(8), .P_VIEW_CYC(50), .P_ERR_CYC(20)) dut (
    .clk_in(clk_in), .srst_in(srst_in), .axi_in(axi), .axi_out(rsp),
    .flow_in(fl), .dens_in(dn), .disp_key_in(kd), .batch_key_in(kb),
    .fault_cond_in(fc), .view_out(view), .fault_lamp_out(lamp),
    .fault_ctrl_out(fctl), .flow_out(flow_o), .disp_out(disp_o),
    .total_out(tot), .batch_out(bat), .dens_out(dens_o), .pcomp_out(pc));

  task automatic chk(input string s, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", s, exp, seen);
    end
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // bounds every wait on the design
  task automatic guard(inout int k);
    k++;
    if (k > 400) begin
      fail_count++;
      $display("ERROR wait expected answer seen timeout");
      conclude();
    end
  endtask
  // k edges, then settle on the falling edge
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_in);
    @(negedge clk_in);
  endtask
  task automatic wr(input logic [31:0] a, d);
    int k;
    k = 0;
    @(posedge clk_in);
    axi.awaddr <= a;
    axi.wdata <= d;
    axi.wstrb <= ws;
    axi.awvalid <= 1'b1;
    axi.wvalid <= 1'b1;
    axi.bready <= 1'b1;
    do begin
      @(posedge clk_in);
      guard(k);
      if (rsp.awready) axi.awvalid <= 1'b0;
      if (rsp.wready) axi.wvalid <= 1'b0;
    end while ((axi.awvalid && !rsp.awready) || (axi.wvalid && !rsp.wready));
    while (!rsp.bvalid) begin
      @(posedge clk_in);
      guard(k);
    end
    rd_r = rsp.bresp;
    axi.bready <= 1'b0;
  endtask
  task automatic rd(input logic [31:0] a);
    int k;
    k = 0;
    @(posedge clk_in);
    axi.araddr <= a;
    axi.arvalid <= 1'b1;
    axi.rready <= 1'b1;
    do begin
      @(posedge clk_in);
      guard(k);
    end while (!rsp.arready);
    axi.arvalid <= 1'b0;
    do begin
      @(posedge clk_in);
      guard(k);
    end while (!rsp.rvalid);
    rd_d = rsp.rdata;
    rd_r = rsp.rresp;
    axi.rready <= 1'b0;
  endtask

  initial begin
    repeat (4) @(posedge clk_in);
    srst_in <= 1'b0;
    // reset values, last address unmapped
    for (int i = 0; i < 8; i++) begin
      rd(ra[i]);
      chk("reset value", rd_d, rv[i]);
      chk("reset resp", {30'h0, rd_r}, (i == 7) ? 32'h2 : 32'h0);
    end
    $display("reset test done");
    // locked writes ignored, wrong code, then right code
    wr(A_CUT, 32'h0);
    rd(A_CUT);
    chk("locked cut", rd_d, 32'h6300);
    wr(A_CODE, 32'h1234);
    rd(A_STATUS);
    chk("code error", rd_d & 32'h3, 32'h2);
    cyc(30);
    rd(A_STATUS);
    chk("reprompt", rd_d & 32'h3, 32'h0);
    wr(A_CODE, 32'h2207);
    rd(A_STATUS);
    chk("unlocked", rd_d & 32'h1, 32'h1);
    $display("access test done");
    // filter passes samples straight through for the table
    wr(A_FILT, 32'h0);
    foreach (rows[i]) begin
      wr(A_CTRL, rows[i].ctrl);
      wr(A_CUT, rows[i].cut);
      wr(A_KFAC, rows[i].kfac);
      fe.set_meas(rows[i].f, rows[i].d);
      cyc(24);
      chk("flow", flow_o, rows[i].q);
      chk("display", disp_o, rows[i].q);
      chk("density", {16'h0, dens_o}, {16'h0, rows[i].d});
      tv = tot;
      bv = bat;
      cyc(16);
      if (rows[i].q == 0) begin
        chk("total hold", tot, tv);
        chk("batch hold", bat, bv);
      end
    end
    $display("table test done");
    // large step reloads the filter at once
    wr(A_CUT, 32'h6300);
    fe.set_meas(16'sh7000, 16'h100);
    cyc(24);
    wr(A_FILT, 32'h4);
    fe.set_meas(-16'sh7000, 16'h100);
    cyc(16);
    chk("step reload", flow_o, -32'sh7000);
    // density cutoff stops counting while clears are tried
    wr(A_CUT, 32'hFFFF6300);
    cyc(8);
    wr(A_CMD, 32'h1);
    cyc(8);
    chk("total clear", tot, 32'h0);
    tv = bat;
    fe.press(1'b1);
    cyc(8);
    chk("key disabled", bat, tv);
    wr(A_CTRL, 32'hC);
    fe.press(1'b1);
    cyc(8);
    chk("key enabled", bat, 32'h0);
    $display("counter test done");
    // fixed view toggled by key, then alternating period
    wr(A_CTRL, 32'h8);
    cyc(8);
    v1 = view;
    fe.press(1'b0);
    cyc(8);
    chk("view key", {31'h0, view}, {31'h0, !v1});
    wr(A_CTRL, 32'h9);
    n = 0;
    c = 0;
    v1 = view;
    while (view === v1) begin
      @(posedge clk_in);
      guard(n);
    end
    v1 = view;
    while (view === v1) begin
      @(posedge clk_in);
      guard(n);
      c++;
    end
    chk("view period", c, 32'd50);
    for (int p = 0; p < 3; p++) begin
      wr(A_CTRL, 32'h8 | (p << 4));
      cyc(8);
      chk("pressure mode", {30'h0, pc}, p);
    end
    $display("view test done");
    // fault delays: on two samples, off three
    wr(A_FDLY, 32'h30002);
    fe.set_fault(1'b1);
    cyc(4);
    chk("fault early", {31'h0, lamp}, 32'h0);
    cyc(32);
    chk("fault on", {30'h0, lamp, fctl}, 32'h3);
    fe.set_fault(1'b0);
    cyc(4);
    chk("fault held", {31'h0, fctl}, 32'h1);
    cyc(40);
    chk("fault off", {31'h0, lamp}, 32'h0);
    fe.set_fault(1'b1);
    cyc(5);
    fe.set_fault(1'b0);
    cyc(40);
    chk("fault glitch", {31'h0, lamp}, 32'h0);
    $display("fault test done");
    // backup store, then recall over a changed scale factor
    wr(A_CMD, 32'h2);
    wr(A_KFAC, 32'h1234);
    wr(A_CMD, 32'h4);
    rd(A_KFAC);
    chk("recall", rd_d, 32'h4000);
    // byte strobe merges the low byte only
    ws = 4'h1;
    wr(A_KFAC, 32'hFFFF0012);
    ws = 4'hF;
    rd(A_KFAC);
    chk("strobe merge", rd_d, 32'h4012);
    // meter mode change: decline keeps mode and total, confirm resets units, total
    wr(A_CUT, 32'h6300);
    cyc(24);
    wr(A_CUT, 32'hFFFF6300);
    cyc(8);
    tv = tot;
    wr(A_CTRL, 32'h100);
    wr(A_CMD, 32'h10);
    rd(A_CTRL);
    chk("mode declined", rd_d, 32'h108);
    chk("total kept", tot, tv);
    wr(A_CTRL, 32'h100);
    wr(A_CMD, 32'h8);
    rd(A_CTRL);
    chk("mode confirmed", rd_d, 32'h0);
    chk("total reset", tot, 32'h0);
    wr(A_STATUS, 32'h1);
    chk("read-only write", {30'h0, rd_r}, {30'h0, RESP_SLVERR});
    $display("settings test done");
    conclude();
  end
endmodule
`default_nettype wire
